// [design/ops_defs.svh]
// Purpose: constants of the order pair sequencer
// Assumes: 40-bit order word, 10-bit instructions and addresses
// Notes: opcode values are local choices
`ifndef OPS_DEFS_SVH
`define OPS_DEFS_SVH

// Register byte offsets
`define OPS_REG_CTRL 8'h00
`define OPS_REG_STATUS 8'h04
`define OPS_REG_COUNTER 8'h08
`define OPS_REG_DECODE 8'h0C
`define OPS_REG_OWR_LO 8'h10
`define OPS_REG_OWR_HI 8'h14

// Field positions in the order word
`define OPS_LI_HI 9
`define OPS_LI_LO 0
`define OPS_LA_HI 19
`define OPS_LA_LO 10
`define OPS_RI_HI 29
`define OPS_RI_LO 20
`define OPS_RA_HI 39
`define OPS_RA_LO 30

// Reset values and counter step
`define OPS_RST_CC 10'h000
`define OPS_RST_OWR 40'h00_0000_0000
`define OPS_RST_DEC 10'h000
`define OPS_CC_STEP 10'h001

// Instruction codes decoded by the sequencer
`define OPS_OP_U 10'h001
`define OPS_OP_UP 10'h002
`define OPS_OP_C 10'h003
`define OPS_OP_CP 10'h004
`define OPS_OP_XFER 10'h005
`define OPS_OP_STOP 10'h006

`endif

// [design/ops_pkg.sv]
// Purpose: types of the order pair sequencer
// Assumes: constants from ops_defs.svh
// Notes: one struct carries all sequencer state
`include "ops_defs.svh"
package ops_pkg;

  typedef enum logic [1:0] {PH_STEP, PH_FMU, PH_EXEC} ops_phase_type;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    ops_phase_type ph;
    logic run;
    logic jtak;
    logic jprim;
    logic [9:0] cc;
    logic [39:0] owr;
    logic [9:0] dec;
    logic mem_req;
    logic [9:0] mem_addr;
    logic fmu;
    logic exec_start;
    logic lgate;
    logic rgate;
    logic agate;
    logic dload;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ops_state_type;

endpackage : ops_pkg

// [design/ops_dec_if.sv]
// Purpose: link between sequencer and order decoder
// Assumes: one clock domain, purely combinational decode
// Notes: none
`timescale 1ns/1ps
interface ops_dec_if;
  logic [9:0] instr;
  logic acc_sign;
  logic left_taken;
  logic right_taken;
  logic xfer;
  logic stop;
  modport dec
  (
    input instr, acc_sign,
    output left_taken, right_taken, xfer, stop
  );
  modport seq
  (
    output instr, acc_sign,
    input left_taken, right_taken, xfer, stop
  );
endinterface : ops_dec_if

// [design/ops_decoder.sv]
// Purpose: decode jump, address-transfer and stop orders
// Assumes: instruction word presented on the interface
// Notes: conditional forms look only at the accumulator sign
`timescale 1ns/1ps
`include "ops_defs.svh"
module ops_decoder
  import ops_pkg::*;
(
  // Decoder side
  ops_dec_if.dec d
);

  ////////////////////////////////////////////////////////////////
  // [RULE13] jump taken decode
  // [RULE10] conditional only on sign zero
  assign d.left_taken = (d.instr == `OPS_OP_U) | ((d.instr == `OPS_OP_C) & ~d.acc_sign);
  assign d.right_taken = (d.instr == `OPS_OP_UP) | ((d.instr == `OPS_OP_CP) & ~d.acc_sign);
  assign d.xfer = (d.instr == `OPS_OP_XFER);
  assign d.stop = (d.instr == `OPS_OP_STOP);

endmodule : ops_decoder

// [design/ops_sequencer.sv]
// Purpose: order pair sequencer with APB register access
// Assumes: mem_done and exec_done are one-cycle pulses
// Notes: flags a, b, c step through the fetch/gate/execute cycle
// Notes on behaviour
// [RULE1] In state a0 b0 c1 the left-instruction gate is asserted.
// [RULE2] Decode-load strobe is left gate, or right gate with address gate.
// [RULE3] Strobe plus execute permit clears the control flag to operate.
// [RULE4] Entering operate starts execution and loads a with not b.
// [RULE5] Execution completion sets the control flag back to one.
// [RULE6] In state a1 b0 c1 the second flag is set.
// [RULE7] In state a1 b1 c1 bits 20-29 go to decode, 30-39 to 10-19.
// [RULE8] After the right instruction the flags return to a0 b1 c1.
// [RULE9] Four jumps: unprimed resume left, primed resume right.
// [RULE10] Conditional jumps are taken only when accumulator sign is zero.
// [RULE11] A taken jump loads the counter and marks the pair as done.
// [RULE12] Address-transfer and stop orders load the counter first.
// [RULE13] Decoder raises left or right jump-taken signals.
// [RULE14] A taken jump forces b to one and a to zero on operate.
// [RULE15] False memory use requests one cycle loading the counter.
// [RULE16] After that cycle control returns, then the target pair is fetched.
// [RULE17] Unprimed jump clears b after the target fetch.
// [RULE18] Primed jump sets a after the target fetch, then right gates.
// [RULE19] Fetch loads the pair at the counter and increments it.
// [RULE20] Left gate copies bits 0-9 into the decode register.
// [RULE21] Flags update on one clock; reset gives a0 b1 c1.
`timescale 1ns/1ps
`include "ops_defs.svh"
module ops_sequencer
  import ops_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory synchronizer
  output logic mem_req,
  output logic [9:0] mem_addr,
  output logic false_use_memory,
  input wire logic mem_done,
  input wire logic [39:0] mem_rdata,
  // Arithmetic unit
  input wire logic accumulator_sign,
  input wire logic execute_start_permit,
  output logic exec_start,
  input wire logic exec_done,
  output logic [9:0] instruction_decode_register,
  // Gates
  output logic left_gate,
  output logic right_gate,
  output logic addr_gate,
  output logic decode_load_strobe
);

  ////////////////////////////////////////////////////////////////
  // State and decoder
  ops_state_type s, n;
  ops_dec_if dif ();
  logic [9:0] gate_word;
  logic [9:0] gate_addr;
  logic taken;
  logic wr_en;

  assign gate_word = s.a ? s.owr[`OPS_RI_HI:`OPS_RI_LO] : s.owr[`OPS_LI_HI:`OPS_LI_LO];
  assign gate_addr = s.a ? s.owr[`OPS_RA_HI:`OPS_RA_LO] : s.owr[`OPS_LA_HI:`OPS_LA_LO];
  // Decode the word being gated so the jump is known on operate entry
  assign dif.instr = gate_word;
  assign dif.acc_sign = accumulator_sign;
  assign taken = dif.left_taken | dif.right_taken;
  assign wr_en = psel & penable & s.pready & pwrite;

  ops_decoder u_dec
  (
    .d(dif.dec)
  );

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    n = s;
    n.exec_start = 1'b0;
    n.pready = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel & ~penable)
    begin
      case (paddr)
        `OPS_REG_CTRL: n.prdata = {31'h0000_0000, s.run};
        `OPS_REG_STATUS: n.prdata = {24'h00_0000, s.jprim, s.jtak, s.fmu, s.mem_req, s.ph == PH_EXEC, s.a, s.b, s.c};
        `OPS_REG_COUNTER: n.prdata = {22'h00_0000, s.cc};
        `OPS_REG_DECODE: n.prdata = {22'h00_0000, s.dec};
        `OPS_REG_OWR_LO: n.prdata = {12'h000, s.owr[`OPS_LA_HI:`OPS_LI_LO]};
        `OPS_REG_OWR_HI: n.prdata = {12'h000, s.owr[`OPS_RA_HI:`OPS_RI_LO]};
        default:
        begin
          n.prdata = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en & (paddr == `OPS_REG_CTRL))
    begin
      n.run = pwdata[0];
    end
    // Counter is only writable while stopped, so no race with fetch
    if (wr_en & (paddr == `OPS_REG_COUNTER) & ~s.run)
    begin
      n.cc = pwdata[9:0];
    end
    // [RULE21] single synchronous flag update
    case (s.ph)
      PH_STEP:
      begin
        if (s.run & s.c)
        begin
          case ({s.a, s.b})
            2'b01:
            begin
              // [RULE19] fetch pair and step counter
              if (~s.mem_req)
              begin
                n.mem_req = 1'b1;
                n.mem_addr = s.cc;
              end
              else if (mem_done)
              begin
                n.mem_req = 1'b0;
                n.owr = mem_rdata;
                n.cc = s.cc + `OPS_CC_STEP;
                n.jtak = 1'b0;
                // [RULE18] primed jump goes to right gate
                if (s.jtak & s.jprim)
                begin
                  n.a = 1'b1;
                end
                // [RULE17] unprimed and normal go left
                else
                begin
                  n.b = 1'b0;
                end
              end
            end
            2'b10:
            begin
              // [RULE6] select right instruction
              n.b = 1'b1;
            end
            default:
            begin
              // [RULE3] strobe and permit enter operate
              if (s.dload & execute_start_permit)
              begin
                n.c = 1'b0;
                // [RULE20] left gate copy
                // [RULE7] right gate copy
                n.dec = gate_word;
                if (s.a)
                begin
                  n.owr[`OPS_LA_HI:`OPS_LA_LO] = s.owr[`OPS_RA_HI:`OPS_RA_LO];
                end
                // [RULE4] a takes inverse of b
                n.a = ~s.b;
                // [RULE14] jump forces b high, a low
                // [RULE11] pair marked done
                if (taken)
                begin
                  n.a = 1'b0;
                  n.b = 1'b1;
                  n.jtak = 1'b1;
                  // [RULE9] primed forms resume right
                  n.jprim = dif.right_taken;
                end
                // [RULE15] false memory use on jump, transfer, stop
                // [RULE12] address field to counter first
                if (taken | dif.xfer | dif.stop)
                begin
                  n.fmu = 1'b1;
                  n.mem_req = 1'b1;
                  n.mem_addr = gate_addr;
                  n.ph = PH_FMU;
                end
                else
                begin
                  n.exec_start = 1'b1;
                  n.ph = PH_EXEC;
                end
              end
            end
          endcase
        end
      end
      PH_FMU:
      begin
        if (mem_done)
        begin
          n.cc = s.mem_addr;
          n.mem_req = 1'b0;
          n.fmu = 1'b0;
          // [RULE16] back to control, then target fetch
          if (s.jtak)
          begin
            n.c = 1'b1;
            n.ph = PH_STEP;
          end
          else
          begin
            n.exec_start = 1'b1;
            n.ph = PH_EXEC;
          end
        end
      end
      PH_EXEC:
      begin
        // [RULE5] completion returns control
        // [RULE8] after right order flags are a0 b1 c1
        if (exec_done)
        begin
          n.c = 1'b1;
          n.ph = PH_STEP;
        end
      end
      default:
      begin
        n.ph = PH_STEP;
      end
    endcase
    // [RULE1] left gate in a0 b0 c1
    n.lgate = n.run & n.c & ~n.a & ~n.b & (n.ph == PH_STEP);
    n.rgate = n.run & n.c & n.a & n.b & (n.ph == PH_STEP);
    n.agate = n.rgate;
    // [RULE2] decode-load strobe
    n.dload = n.lgate | (n.rgate & n.agate);
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // [RULE21] reset into fetch state
      s <= '{a: 1'b0, b: 1'b1, c: 1'b1, ph: PH_STEP, run: 1'b0, jtak: 1'b0, jprim: 1'b0,
             cc: `OPS_RST_CC, owr: `OPS_RST_OWR, dec: `OPS_RST_DEC, mem_req: 1'b0,
             mem_addr: `OPS_RST_CC, fmu: 1'b0, exec_start: 1'b0, lgate: 1'b0, rgate: 1'b0,
             agate: 1'b0, dload: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign mem_req = s.mem_req;
  assign mem_addr = s.mem_addr;
  assign false_use_memory = s.fmu;
  assign exec_start = s.exec_start;
  assign instruction_decode_register = s.dec;
  assign left_gate = s.lgate;
  assign right_gate = s.rgate;
  assign addr_gate = s.agate;
  assign decode_load_strobe = s.dload;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_left_gate_state: assert property (left_gate |-> s.c & ~s.a & ~s.b) // [RULE1]
    else $error("left gate outside a0 b0 c1");
  a_strobe_gates: assert property (decode_load_strobe == (left_gate | (right_gate & addr_gate))) // [RULE2]
    else $error("decode strobe mismatch");
  a_op_turnover: assert property ((s.ph == PH_STEP) & s.run & decode_load_strobe & execute_start_permit
    |=> ~s.c & ~decode_load_strobe) // [RULE3]
    else $error("operate not entered");
  a_exec_begins: assert property ($fell(s.c) & ~s.fmu |-> exec_start & (s.a == ~$past(s.b))) // [RULE4]
    else $error("execution start or a flag wrong");
  a_done_control: assert property ((s.ph == PH_EXEC) & exec_done |=> s.c ##1 (s.ph == PH_STEP)) // [RULE5]
    else $error("control not restored");
  a_right_select: assert property ((s.ph == PH_STEP) & s.run & s.c & s.a & ~s.b |=> s.b & right_gate) // [RULE6]
    else $error("right not selected");
  a_right_copy: assert property (right_gate & execute_start_permit & s.run
    |=> s.dec == $past(s.owr[`OPS_RI_HI:`OPS_RI_LO])
    && s.owr[`OPS_LA_HI:`OPS_LA_LO] == $past(s.owr[`OPS_RA_HI:`OPS_RA_LO])) // [RULE7]
    else $error("right copy wrong");
  a_jump_force: assert property ($fell(s.c) & s.jtak |-> s.b & ~s.a & false_use_memory) // [RULE14]
    else $error("jump flags not forced");
  a_fetch_step: assert property (s.c & ~s.a & s.b & mem_req & ~s.fmu & mem_done & s.run
    |=> s.cc == $past(s.cc) + `OPS_CC_STEP && (left_gate | right_gate)) // [RULE19]
    else $error("fetch did not step counter");

  c_jump_taken: cover property ($rose(false_use_memory) & s.jtak);
  c_primed_jump: cover property (s.jtak & s.jprim & mem_done ##1 s.a & s.b);
  c_odd_exec: cover property (right_gate ##[1:4] exec_start);

endmodule : ops_sequencer

// [verification/ops_far_model.sv]
// Purpose: far-side model, memory synchronizer and arithmetic unit
// Assumes: one clock; request held until done, done is a one-cycle pulse
// Notes: slow mode lengthens both answers and gaps the execute permit
`timescale 1ns/1ps
module ops_far_model
(
  // Clock, reset and slow mode select
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // Memory side
  input wire logic mem_req,
  input wire logic [9:0] mem_addr,
  output logic mem_done,
  output logic [39:0] mem_rdata,
  // Arithmetic side
  input wire logic exec_start,
  output logic exec_done,
  output logic execute_start_permit
);
  logic [39:0] mem [0:1023];
  logic [39:0] last_q;
  logic busy_q;
  logic [3:0] mcnt_q;
  logic [3:0] ecnt_q;
  logic [3:0] tick_q;
  logic [3:0] lat;

  // Released data shows the inverse, so stale words never look valid
  assign mem_rdata = mem_done ? last_q : ~last_q;
  assign execute_start_permit = !slow || tick_q[1];
  assign lat = slow ? 4'h4 : 4'h0;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_done <= 1'b0;
      exec_done <= 1'b0;
      last_q <= 40'h00_0000_0000;
      busy_q <= 1'b0;
      mcnt_q <= 4'h0;
      ecnt_q <= 4'h0;
      tick_q <= 4'h0;
    end
    else
    begin
      tick_q <= tick_q + 4'h1;
      mem_done <= 1'b0;
      exec_done <= 1'b0;
      if (mem_req && !mem_done)
      begin
        if (mcnt_q >= lat)
        begin
          mem_done <= 1'b1;
          mcnt_q <= 4'h0;
          last_q <= mem[mem_addr];
        end
        else
          mcnt_q <= mcnt_q + 4'h1;
      end
      if (exec_start)
      begin
        busy_q <= 1'b1;
        ecnt_q <= 4'h0;
      end
      else if (busy_q)
      begin
        if (ecnt_q >= lat)
        begin
          exec_done <= 1'b1;
          busy_q <= 1'b0;
        end
        else
          ecnt_q <= ecnt_q + 4'h1;
      end
    end
  end
endmodule : ops_far_model

// [verification/testbench.sv]
// Purpose: self-checking bench of the order pair sequencer
// Assumes: APB answers with pready; far side is the behavioural model
// Notes: traces of executed orders and memory cycles are compared in order
`timescale 1ns/1ps
`include "ops_defs.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, mem_req, false_use_memory, mem_done, exec_start, exec_done;
  logic [9:0] mem_addr, instruction_decode_register;
  logic [39:0] mem_rdata;
  logic accumulator_sign = 1'b0;
  logic execute_start_permit, slow = 1'b0;
  logic left_gate, right_gate, addr_gate, decode_load_strobe;
  logic [9:0] ex_q[$];
  logic [10:0] mq[$];
  int error_cnt = 0;
  int checked = 0;

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  ops_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_addr(mem_addr), .false_use_memory(false_use_memory), .mem_done(mem_done), .mem_rdata(mem_rdata),
    .accumulator_sign(accumulator_sign), .execute_start_permit(execute_start_permit), .exec_start(exec_start),
    .exec_done(exec_done), .instruction_decode_register(instruction_decode_register), .left_gate(left_gate),
    .right_gate(right_gate), .addr_gate(addr_gate), .decode_load_strobe(decode_load_strobe));
  ops_far_model u_far (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .exec_start(exec_start), .exec_done(exec_done),
    .execute_start_permit(execute_start_permit));

  // Trace monitor: values seen at the edge, before that edge's updates land
  always @(posedge pclk)
  begin
    if (exec_start === 1'b1)
      ex_q.push_back(instruction_decode_register);
    if (mem_req === 1'b1 && mem_done === 1'b1)
      mq.push_back({false_use_memory, mem_addr});
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // Held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [39:0] pair(input logic [9:0] li, input logic [9:0] la, input logic [9:0] ri);
    return {10'h000, ri, la, li};
  endfunction : pair

  // Fresh reset, program words 0 and 5, start, collect the traces
  task automatic run_prog(input logic [39:0] w0, input logic sign, input logic sl, input int ne, input int nm);
    logic [31:0] rd;
    logic err;
    int n;
    presetn <= 1'b0;
    for (int i = 0; i < 1024; i++)
      u_far.mem[i] = 40'h00_0000_0000;
    u_far.mem[0] = w0;
    u_far.mem[5] = pair(10'h050, 10'h000, 10'h060);
    accumulator_sign <= sign;
    slow <= sl;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    ex_q.delete();
    mq.delete();
    @(posedge pclk);
    apb(1'b1, `OPS_REG_CTRL, 32'h0000_0001, rd, err);
    n = 0;
    while ((ex_q.size() < ne || mq.size() < nm) && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n < 400, 1'b1);
  endtask : run_prog

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_regs;
    logic [31:0] rd;
    logic err;
    run_prog(40'h00_0000_0000, 1'b0, 1'b0, 0, 0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OPS_REG_STATUS, 32'h0, rd, err);
    chk(rd, 32'h0000_0003);
    apb(1'b0, `OPS_REG_DECODE, 32'h0, rd, err);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `OPS_REG_OWR_HI, 32'h0, rd, err);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `OPS_REG_COUNTER, 32'h0000_02AB, rd, err);
    apb(1'b0, `OPS_REG_COUNTER, 32'h0, rd, err);
    chk(rd, 32'h0000_02AB);
    apb(1'b0, 8'h18, 32'h0, rd, err);
    chk({err, rd}, 33'h1_0000_0000);
  endtask : sc_regs

  task automatic sc_normal;
    run_prog(pair(10'h010, 10'h000, 10'h020), 1'b0, 1'b1, 3, 2);
    chk(ex_q[0], 10'h010);
    chk(ex_q[1], 10'h020);
    chk(mq[0], 11'h000);
    chk(mq[1], 11'h001);
  endtask : sc_normal

  task automatic sc_jump(input logic [9:0] op, input logic sign, input logic taken, input logic primed);
    run_prog(pair(op, 10'h005, 10'h040), sign, 1'b0, 2, 3);
    // A taken jump runs as a counter-loading cycle, never as an execution
    if (taken)
    begin
      chk(ex_q[0], primed ? 10'h060 : 10'h050);
      chk(mq[1], 11'h405);
      chk(mq[2], 11'h005);
      chk(ex_q[1], primed ? 10'h000 : 10'h060);
    end
    else
    begin
      chk(ex_q[0], op);
      chk(ex_q[1], 10'h040);
      chk(mq[1], 11'h001);
    end
  endtask : sc_jump

  task automatic sc_xfer(input logic [9:0] op);
    run_prog(pair(op, 10'h007, 10'h040), 1'b0, 1'b0, 2, 3);
    chk(mq[1], 11'h407);
    chk(ex_q[0], op);
    chk(ex_q[1], 10'h040);
    chk(mq[2], 11'h007);
  endtask : sc_xfer

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    sc_regs();
    sc_normal();
    sc_jump(`OPS_OP_U, 1'b1, 1'b1, 1'b0);
    sc_jump(`OPS_OP_UP, 1'b0, 1'b1, 1'b1);
    sc_jump(`OPS_OP_C, 1'b0, 1'b1, 1'b0);
    sc_jump(`OPS_OP_C, 1'b1, 1'b0, 1'b0);
    sc_jump(`OPS_OP_CP, 1'b0, 1'b1, 1'b1);
    sc_jump(`OPS_OP_CP, 1'b1, 1'b0, 1'b1);
    sc_xfer(`OPS_OP_XFER);
    sc_xfer(`OPS_OP_STOP);
    wrap_up();
  end
endmodule : testbench
